// file: rtl/p0m_page0_map.sv
/*
 * p0m_page0_map: page-0 address decoder, ram control and mode latch
 * registers, and the cpu register set (general registers, pc, status word).
 * assumes the cpu core drives the request ports on clk and that mode pins
 * are asynchronous levels held stable around the release of arst_n.
 * the pins must stay put for three clocks after release, as the
 * latch is taken only once they have crossed the synchroniser.
 * instruction execution and page registers live in the cpu core.
 */
// Operation
// - space is 64k pages; 16 only in maximum
// - top 128 page-0 addresses are registers
// - vectors on rom in modes 2,4
// - ram enable maps 1k window on-chip
// - ram enable is bit 7 at fff9
// - single-chip with ram off: address error
// - mode pins latched at reset release, read-only
// - latch bits 2..0 follow high, mid, low pins
// - latch bits 7,6 one; 5..3 zero
// - eight 16-bit general registers, byte or word
// - register 7 is stack pointer, auto step
// - register 6 is frame pointer
// - 16-bit program counter of next instruction
// - 16-bit status word, low byte separately writable
// - trace bit raises exception per instruction
// - status bits 14..11 read zero
// - mask level gates maskable, nmi always taken
// - accepted interrupt loads its level into mask
// - reset sets mask to seven
// - cpu mode follows latched mode
// - only codes 1,2,3,4,7 are legal
// - mode table: space size, rom use
`timescale 1ns/1ns
`default_nettype none
module p0m_page0_map #(
    parameter logic [15:0] VEC_TOP = 16'h00ff     // end of the vector area
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // mode pins, asynchronous
    input wire logic mode_pin_high,
    input wire logic mode_pin_mid,
    input wire logic mode_pin_low,
    // cpu memory access
    input wire logic [p0m_pkg::P0M_PAGE_BITS-1:0] acc_page,
    input wire logic [p0m_pkg::P0M_OFS_BITS-1:0] acc_addr,
    input wire logic acc_rd,
    input wire logic acc_wr,
    input wire logic [7:0] acc_wdata,
    output p0m_pkg::p0m_target_t acc_target,
    output logic acc_addr_error,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // operating mode view
    output logic [2:0] mode_latch_bits,
    output logic cpu_max_mode,
    output logic onchip_ram_enable,
    // general register write and read
    input wire logic gr_wr,
    input wire logic gr_byte,
    input wire logic [2:0] gr_widx,
    input wire logic [15:0] gr_wdata,
    input wire logic [2:0] gr_ridx_a,
    input wire logic [2:0] gr_ridx_b,
    output logic [15:0] gr_rdata_a,
    output logic [15:0] gr_rdata_b,
    // stack pointer steps
    input wire logic sp_predec,
    input wire logic sp_postinc,
    input wire logic sp_byte,
    output logic [15:0] stack_ptr,
    output logic [15:0] frame_ptr,
    // program counter
    input wire logic pc_load,
    input wire logic [15:0] pc_ldata,
    input wire logic pc_adv,
    input wire logic [2:0] pc_adv_len,
    output logic [15:0] prog_counter,
    // status word
    input wire logic sr_wr,
    input wire logic sr_ccr_only,
    input wire logic [15:0] sr_wdata,
    output logic [15:0] cpu_status_word,
    // instruction retire and trace
    input wire logic instr_done,
    output logic trace_req,
    // interrupt requests
    input wire logic [2:0] irq_level,
    input wire logic nmi_req,
    output logic irq_accept
);
    import p0m_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // mode pin synchroniser and latch

    // straps have no timing relation to clk, so two stages come first
    // and only the second one is ever read by the latch
    logic [2:0] pin_s1_q;       // first stage, read only by second
    logic [2:0] pin_s2_q;       // second stage
    logic [2:0] mode_q;         // latched mode pins
    logic [1:0] settle_q;       // counts sync stages after release
    logic captured_q;           // latch taken once

    // two flops before anything looks at the pins
    // reset clears both stages; the capture waits past them anyway
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
        end
        else
        begin
            pin_s1_q <= {mode_pin_high, mode_pin_mid, mode_pin_low};
            pin_s2_q <= pin_s1_q;
        end
    end

    // capture once the synchroniser holds post-release samples; no later
    // change of the pins reaches the latch, and no cpu write does either
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            settle_q <= 2'h0;
            captured_q <= 1'b0;
            mode_q <= P0M_MODE_RST;
        end
        else if (!captured_q)
        begin
            // count 0, 1, 2: the third edge sees post-release samples
            settle_q <= 2'(settle_q + 2'h1);
            if (settle_q == 2'h2)
            begin
                captured_q <= 1'b1;
                mode_q <= pin_s2_q;
            end
        end
    end

    // until capture the latch reads 3'b111, single chip, which keeps every
    // off-chip decode but the vector area blocked in the first clocks
    assign mode_latch_bits = mode_q;

    ////////////////////////////////////////////////////////////////////////
    // mode decode
    // 1, 2: expanded minimum, 64k bytes; 3, 4: expanded maximum, 1m
    // 7: single chip, nothing off chip but the vector area; rom is off in modes 1 and 3
    // the cpu itself only knows minimum and maximum

    wire mode_max = (mode_q == P0M_MODE_3) || (mode_q == P0M_MODE_4);
    wire mode_single = (mode_q == P0M_MODE_7);
    wire rom_on = (mode_q == P0M_MODE_2) || (mode_q == P0M_MODE_4) || mode_single;
    // codes 0, 5 and 6 must never be applied; treat them as erroring
    wire mode_legal = (mode_q == P0M_MODE_1) || (mode_q == P0M_MODE_2) ||
                      mode_max || mode_single;

    // codes 0, 5 and 6 leave every access in error, a visible symptom
    assign cpu_max_mode = mode_max;

    ////////////////////////////////////////////////////////////////////////
    // address decode

    // the ram window is the 1 kbyte directly below the register field
    // only page 0 holds on-chip resources; other pages go off chip in modes 3 and 4, error otherwise
    logic ram_en_q;             // ram_control bit 7
    wire acc_any = acc_rd || acc_wr;
    wire page_ok = mode_max || (acc_page == P0M_PAGE_ZERO);
    wire in_page0 = (acc_page == P0M_PAGE_ZERO);
    wire hit_regf = in_page0 && (acc_addr >= P0M_REGF_LO);
    wire hit_ram = in_page0 && (acc_addr >= P0M_RAM_LO) && (acc_addr <= P0M_RAM_HI);
    wire hit_vec = in_page0 && (acc_addr <= VEC_TOP);
    wire hit_rom = in_page0 && (acc_addr <= P0M_ROM_HI);
    // vectors come from rom only in modes 2 and 4
    wire vec_on_rom = (mode_q == P0M_MODE_2) || (mode_q == P0M_MODE_4);
    wire ram_off_err = mode_single && hit_ram && !ram_en_q;

    // priority: register field first, independent of ram enable and mode
    // only an illegal mode or page comes ahead of it
    // limitation: the rom window is fixed at 32k bytes from the bottom
    always_comb
    begin
        if (!mode_legal || !page_ok)
            acc_target = P0M_TGT_ERR;
        else if (hit_regf)
            acc_target = P0M_TGT_REG;
        else if (hit_ram)
            acc_target = ram_en_q ? P0M_TGT_RAM :
                         (ram_off_err ? P0M_TGT_ERR : P0M_TGT_EXT);
        else if (hit_vec)
            acc_target = vec_on_rom ? P0M_TGT_ROM : P0M_TGT_EXT;
        else if (hit_rom && rom_on)
            acc_target = P0M_TGT_ROM;
        // what is left is off chip, which single chip cannot reach
        else
            acc_target = mode_single ? P0M_TGT_ERR : P0M_TGT_EXT;
    end

    // the error flag only rises with a strobe; decode alone is silent
    assign acc_addr_error = acc_any && (acc_target == P0M_TGT_ERR);

    ////////////////////////////////////////////////////////////////////////
    // ram_control and mode_latch registers

    wire sel_ramc = hit_regf && (acc_addr == P0M_RAM_CONTROL_OFS);
    wire sel_mdl = hit_regf && (acc_addr == P0M_MODE_LATCH_OFS);
    wire [7:0] ramc_view = 8'(ram_en_q) << P0M_ONCHIP_RAM_ENABLE_POS;
    wire [7:0] mdl_view = {P0M_MODE_LATCH_ONES, P0M_MODE_LATCH_ZEROS, mode_q};
    wire [7:0] rd_mux = sel_ramc ? ramc_view : (sel_mdl ? mdl_view : 8'h00);
    logic [7:0] rdata_q;
    logic rvalid_q;

    // trade-off: read data comes from a flop, one clock late, so the
    // read path never runs straight from decode to the data output
    // ram enable write; a write to the mode latch falls through untouched
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ram_en_q <= P0M_ONCHIP_RAM_ENABLE_RST;
        else if (acc_wr && sel_ramc)
            ram_en_q <= acc_wdata[P0M_ONCHIP_RAM_ENABLE_POS];
    end

    // read data one cycle after the strobe; other field bytes read zero
    // those other bytes belong to modules outside this block
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= acc_rd && hit_regf && mode_legal;
            if (acc_rd && hit_regf)
                rdata_q <= rd_mux;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign onchip_ram_enable = ram_en_q;

    ////////////////////////////////////////////////////////////////////////
    // general registers
    // all eight are alike; r6 and r7 only get extra duties
    // a byte write keeps the high byte, with no sign extension

    logic [15:0] gr_q [P0M_NUM_GR];     // r7 doubles as stack pointer
    wire [15:0] sp_step = sp_byte ? 16'h0001 : 16'h0002;
    wire [15:0] gr_byte_val = {gr_q[gr_widx][15:8], gr_wdata[7:0]};
    wire [15:0] gr_new = gr_byte ? gr_byte_val : gr_wdata;

    // explicit write wins over the implicit stack step on r7
    // predecrement wins over postincrement if both are asked for
    // steps are two for word pushes and one for byte pushes
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < P0M_NUM_GR; i++)
                gr_q[i] <= P0M_GR_RST;
        end
        else
        begin
            if (sp_predec)
                gr_q[P0M_SP_IDX] <= 16'(gr_q[P0M_SP_IDX] - sp_step);
            else if (sp_postinc)
                gr_q[P0M_SP_IDX] <= 16'(gr_q[P0M_SP_IDX] + sp_step);
            if (gr_wr)
                gr_q[gr_widx] <= gr_new;
        end
    end

    assign gr_rdata_a = gr_q[gr_ridx_a];
    assign gr_rdata_b = gr_q[gr_ridx_b];
    assign stack_ptr = gr_q[P0M_SP_IDX];
    assign frame_ptr = gr_q[P0M_FP_IDX];

    ////////////////////////////////////////////////////////////////////////
    // program counter

    logic [15:0] pc_q;

    // load wins over advance
    // the advance length is the retired instruction size in bytes
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pc_q <= P0M_PC_RST;
        else if (pc_load)
            pc_q <= pc_ldata;
        else if (pc_adv)
            pc_q <= 16'(pc_q + {13'h0000, pc_adv_len});
    end

    assign prog_counter = pc_q;

    ////////////////////////////////////////////////////////////////////////
    // status word and interrupt acceptance

    logic trace_q;
    logic [2:0] mask_q;
    logic [3:0] ccr_q;          // ccr bits 7..4 are reserved zero

    // level 0 means no request; nmi counts as level 8
    // nmi ignores the mask; maskable needs a level above it
    wire irq_ok = (irq_level != 3'h0) && (irq_level > mask_q);
    assign irq_accept = nmi_req || irq_ok;
    wire [2:0] mask_take = nmi_req ? P0M_MASK_NMI : irq_level;

    // acceptance overrides a same-cycle software write of the mask
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            trace_q <= P0M_TRACE_RST;
            mask_q <= P0M_MASK_RST;
            ccr_q <= P0M_CCR_RST;
        end
        else
        begin
            if (sr_wr)
            begin
                ccr_q <= sr_wdata[3:0];
                if (!sr_ccr_only)
                begin
                    trace_q <= sr_wdata[P0M_SR_TRACE_POS];
                    mask_q <= sr_wdata[P0M_SR_MASK_LO+2:P0M_SR_MASK_LO];
                end
            end
            if (irq_accept)
                mask_q <= mask_take;
        end
    end

    // reserved bits 14..11 and 7..4 always read zero
    // trace request is combinational so the exception logic sees it
    // in the very cycle the instruction retires
    assign cpu_status_word = {trace_q, 4'h0, mask_q, 4'h0, ccr_q};
    assign trace_req = trace_q && instr_done;
endmodule
`default_nettype wire

// file: rtl/p0m_pkg.sv
/*
 * p0m_pkg: constants for the page-0 address map and cpu status block.
 * assumes a byte-addressed space of 16 pages of 64k bytes each.
 */
package p0m_pkg;
    // address space shape
    localparam int unsigned P0M_PAGE_BITS = 4;          // up to 16 pages
    localparam int unsigned P0M_OFS_BITS = 16;          // 64k-byte pages
    localparam logic [3:0] P0M_PAGE_ZERO = 4'h0;
    // register field at the top of page 0
    localparam logic [15:0] P0M_REGF_LO = 16'hff80;     // 128 addresses
    localparam logic [15:0] P0M_REGF_HI = 16'hffff;
    // on-chip ram window, 1 kbyte ending just below the register field
    localparam logic [15:0] P0M_RAM_HI = 16'hff7f;
    localparam logic [15:0] P0M_RAM_BYTES = 16'h0400;
    localparam logic [15:0] P0M_RAM_LO = 16'(P0M_RAM_HI - P0M_RAM_BYTES + 16'h0001);
    // on-chip rom, 32k bytes from the bottom of page 0
    localparam logic [15:0] P0M_ROM_HI = 16'h7fff;
    // register offsets
    localparam logic [15:0] P0M_RAM_CONTROL_OFS = 16'hfff9;
    localparam logic [15:0] P0M_MODE_LATCH_OFS = 16'hfffa;
    // ram_control layout and reset
    localparam int unsigned P0M_ONCHIP_RAM_ENABLE_POS = 7;
    localparam logic P0M_ONCHIP_RAM_ENABLE_RST = 1'b1;
    // mode_latch fixed bits
    localparam logic [1:0] P0M_MODE_LATCH_ONES = 2'h3;  // bits 7..6
    localparam logic [2:0] P0M_MODE_LATCH_ZEROS = 3'h0; // bits 5..3
    localparam logic [2:0] P0M_MODE_RST = 3'h7;         // before capture
    // status word layout
    localparam int unsigned P0M_SR_TRACE_POS = 15;
    localparam int unsigned P0M_SR_MASK_LO = 8;
    localparam logic [2:0] P0M_MASK_RST = 3'h7;
    localparam logic [2:0] P0M_MASK_NMI = 3'h7;
    localparam logic P0M_TRACE_RST = 1'b0;
    localparam logic [3:0] P0M_CCR_RST = 4'h0;
    // general registers
    localparam int unsigned P0M_NUM_GR = 8;
    localparam logic [2:0] P0M_SP_IDX = 3'h7;
    localparam logic [2:0] P0M_FP_IDX = 3'h6;
    localparam logic [15:0] P0M_GR_RST = 16'h0000;
    localparam logic [15:0] P0M_PC_RST = 16'h0000;

    // operating modes as latched from the mode pins
    typedef enum logic [2:0] {
        P0M_MODE_1 = 3'b001,   // expanded minimum, rom off
        P0M_MODE_2 = 3'b010,   // expanded minimum, rom on
        P0M_MODE_3 = 3'b011,   // expanded maximum, rom off
        P0M_MODE_4 = 3'b100,   // expanded maximum, rom on
        P0M_MODE_7 = 3'b111    // single chip
    } p0m_mode_t;

    // where an access lands
    typedef enum logic [2:0] {
        P0M_TGT_EXT = 3'b000,
        P0M_TGT_ROM = 3'b001,
        P0M_TGT_RAM = 3'b010,
        P0M_TGT_REG = 3'b011,
        P0M_TGT_ERR = 3'b100
    } p0m_target_t;
endpackage

// file: dv/p0m_mode_env.sv
/*
 * p0m_mode_env: board-side model that straps the three mode pins.
 * assumes the bench changes the code only while reset is held.
 */
`timescale 1ns/1ns
`default_nettype none
module p0m_mode_env (
    // requested operating mode
    input wire logic [2:0] code,
    // strap levels toward the device
    output logic mode_pin_high,
    output logic mode_pin_mid,
    output logic mode_pin_low
);
    ////////////////////////////////////////////////////////////////////////
    // unusable codes never reach the pins, single chip stands in for them
    wire logic [2:0] legal = (code inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h7}) ? code : 3'h7;
    assign mode_pin_high = legal[2];
    assign mode_pin_mid = legal[1];
    assign mode_pin_low = legal[0];
endmodule
`default_nettype wire

// file: dv/p0m_page0_map_checker.sv
/*
 * p0m_page0_map_checker: port-level properties of the page-0 map block.
 * assumes one clock domain and the async active-low reset.
 */
`timescale 1ns/1ns
`default_nettype none
module p0m_page0_map_checker (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // access side
    input wire logic [3:0] acc_page,
    input wire logic [15:0] acc_addr,
    input wire logic acc_rd,
    input wire logic acc_wr,
    input wire p0m_pkg::p0m_target_t acc_target,
    input wire logic acc_addr_error,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // mode and status
    input wire logic [2:0] mode_latch_bits,
    input wire logic cpu_max_mode,
    input wire logic onchip_ram_enable,
    input wire logic [15:0] cpu_status_word,
    input wire logic instr_done,
    input wire logic trace_req,
    input wire logic [2:0] irq_level,
    input wire logic nmi_req,
    input wire logic irq_accept
);
    import p0m_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////
    // helper decode of the two on-chip windows
    wire logic in_field = (acc_page == 4'h0) && (acc_addr >= 16'hff80);
    wire logic in_ram = (acc_page == 4'h0) && (acc_addr >= 16'hfb80) && (acc_addr <= 16'hff7f);
    sequence field_rd;
        acc_rd && in_field;
    endsequence
    sequence latch_rd;
        acc_rd && in_field && (acc_addr == 16'hfffa);
    endsequence
    sequence latch_wr;
        acc_wr && in_field && (acc_addr == 16'hfffa);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    field_decode_a: assert property (in_field |-> acc_target == P0M_TGT_REG)
        else $error("register field not decoded on chip");
    ram_window_a: assert property (
        in_ram |-> ((acc_target == P0M_TGT_RAM) == onchip_ram_enable))
        else $error("ram window does not follow enable");
    addr_error_a: assert property (
        acc_addr_error == ((acc_rd || acc_wr) && acc_target == P0M_TGT_ERR))
        else $error("address error flag wrong");
    read_answer_a: assert property (field_rd |=> reg_rvalid)
        else $error("register read not answered");
    latch_read_a: assert property (
        latch_rd |=> reg_rdata == {5'h18, mode_latch_bits})
        else $error("mode latch read value wrong");
    latch_fixed_a: assert property (latch_wr |=> $stable(mode_latch_bits))
        else $error("mode latch changed by a write");
    max_mode_a: assert property (
        cpu_max_mode == (mode_latch_bits inside {3'h3, 3'h4}))
        else $error("cpu mode does not follow latch");
    sr_reserved_a: assert property (cpu_status_word[14:11] == 4'h0)
        else $error("reserved status bits set");
    trace_out_a: assert property (trace_req == (cpu_status_word[15] && instr_done))
        else $error("trace request wrong");
    irq_gate_a: assert property (
        irq_accept == (nmi_req || irq_level > cpu_status_word[10:8]))
        else $error("interrupt acceptance wrong");
    mask_load_a: assert property (
        irq_accept |=> cpu_status_word[10:8] == ($past(nmi_req) ? 3'h7 : $past(irq_level)))
        else $error("mask not loaded with level");
endmodule
bind p0m_page0_map p0m_page0_map_checker chk_i (.clk(clk), .arst_n(arst_n), .acc_page(acc_page),
    .acc_addr(acc_addr), .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_target(acc_target),
    .acc_addr_error(acc_addr_error), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .mode_latch_bits(mode_latch_bits), .cpu_max_mode(cpu_max_mode),
    .onchip_ram_enable(onchip_ram_enable), .cpu_status_word(cpu_status_word),
    .instr_done(instr_done), .trace_req(trace_req), .irq_level(irq_level),
    .nmi_req(nmi_req), .irq_accept(irq_accept));
`default_nettype wire

// file: dv/tb.sv
/*
 * tb: self-checking bench for the page-0 map block.
 * assumes the mode strap model and the bound checker are compiled.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import p0m_pkg::*;
    // stimulus, driven on the falling edge
    logic clk = 1'b0, arst_n = 1'b0, acc_rd = 1'b0, acc_wr = 1'b0, gr_wr = 1'b0, gr_byte = 1'b0;
    logic sp_predec = 1'b0, sp_postinc = 1'b0, sp_byte = 1'b0, pc_load = 1'b0, pc_adv = 1'b0;
    logic sr_wr = 1'b0, sr_ccr_only = 1'b0, instr_done = 1'b0, nmi_req = 1'b0;
    logic [3:0] acc_page = 4'h0;
    logic [7:0] acc_wdata = 8'h00;
    logic [15:0] acc_addr = 16'h0000, gr_wdata = 16'h0000;
    logic [15:0] pc_ldata = 16'h0000, sr_wdata = 16'h0000;
    logic [2:0] gr_widx = 3'h0, gr_ridx_a = 3'h0, gr_ridx_b = 3'h0, pc_adv_len = 3'h0;
    logic [2:0] irq_level = 3'h0, env_code = 3'h2;
    // observed
    p0m_target_t acc_target;
    logic acc_addr_error, reg_rvalid, cpu_max_mode, onchip_ram_enable, trace_req, irq_accept;
    logic mode_pin_high, mode_pin_mid, mode_pin_low;
    logic [7:0] reg_rdata;
    logic [2:0] mode_latch_bits;
    logic [15:0] gr_rdata_a, gr_rdata_b, stack_ptr, frame_ptr, prog_counter, cpu_status_word;
    int error_cnt = 0, n_checks = 0;
    // decode rows: mode, page, offset, expected landing place
    logic [25:0] tab [15] = '{
        {3'h2, 4'h0, 16'h0000, P0M_TGT_ROM}, {3'h2, 4'h0, 16'h4000, P0M_TGT_ROM},
        {3'h2, 4'h0, 16'h9000, P0M_TGT_EXT}, {3'h2, 4'h0, 16'hfb80, P0M_TGT_RAM},
        {3'h2, 4'h0, 16'hff7f, P0M_TGT_RAM}, {3'h2, 4'h0, 16'hff80, P0M_TGT_REG},
        {3'h2, 4'h1, 16'h0000, P0M_TGT_ERR}, {3'h1, 4'h0, 16'h0000, P0M_TGT_EXT},
        {3'h1, 4'h0, 16'h4000, P0M_TGT_EXT}, {3'h3, 4'h1, 16'h4000, P0M_TGT_EXT},
        {3'h3, 4'h0, 16'h0000, P0M_TGT_EXT}, {3'h4, 4'h0, 16'h0000, P0M_TGT_ROM},
        {3'h4, 4'h2, 16'h9000, P0M_TGT_EXT}, {3'h7, 4'h0, 16'h4000, P0M_TGT_ROM},
        {3'h7, 4'h0, 16'h9000, P0M_TGT_ERR}};
    ////////////////////////////////////////////////////////////////////////
    always #5 clk = ~clk;
    p0m_mode_env env (.code(env_code), .mode_pin_high(mode_pin_high),
        .mode_pin_mid(mode_pin_mid), .mode_pin_low(mode_pin_low));
    p0m_page0_map uut (.clk(clk), .arst_n(arst_n), .mode_pin_high(mode_pin_high),
        .mode_pin_mid(mode_pin_mid), .mode_pin_low(mode_pin_low), .acc_page(acc_page),
        .acc_addr(acc_addr), .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
        .acc_target(acc_target), .acc_addr_error(acc_addr_error), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .mode_latch_bits(mode_latch_bits), .cpu_max_mode(cpu_max_mode),
        .onchip_ram_enable(onchip_ram_enable), .gr_wr(gr_wr), .gr_byte(gr_byte),
        .gr_widx(gr_widx), .gr_wdata(gr_wdata), .gr_ridx_a(gr_ridx_a), .gr_ridx_b(gr_ridx_b),
        .gr_rdata_a(gr_rdata_a), .gr_rdata_b(gr_rdata_b), .sp_predec(sp_predec),
        .sp_postinc(sp_postinc), .sp_byte(sp_byte), .stack_ptr(stack_ptr),
        .frame_ptr(frame_ptr), .pc_load(pc_load), .pc_ldata(pc_ldata), .pc_adv(pc_adv),
        .pc_adv_len(pc_adv_len), .prog_counter(prog_counter), .sr_wr(sr_wr),
        .sr_ccr_only(sr_ccr_only), .sr_wdata(sr_wdata), .cpu_status_word(cpu_status_word),
        .instr_done(instr_done), .trace_req(trace_req), .irq_level(irq_level),
        .nmi_req(nmi_req), .irq_accept(irq_accept));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic final_report();
        if (error_cnt == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // straps change only under reset; settle well past the capture edge
    task automatic do_reset(input logic [2:0] m);
        @(negedge clk) arst_n = 1'b0;
        env_code = m;
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        repeat (5) @(negedge clk);
    endtask
    // one-cycle register field access; read answer checked one cycle on
    task automatic reg_acc(input logic [15:0] a, input logic w, input logic [7:0] d,
        input logic [7:0] e);
        @(negedge clk);
        acc_addr = a;
        acc_wr = w;
        acc_rd = !w;
        acc_wdata = d;
        @(negedge clk);
        acc_rd = 1'b0;
        acc_wr = 1'b0;
        if (!w)
        begin
            chk(reg_rvalid, 1'b1);
            chk(reg_rdata, e);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watchdog: the whole sequence needs about a hundred cycles
    initial
    begin
        #50000;
        error_cnt++;
        final_report();
    end
    initial
    begin
        for (int i = 0; i < 15; i++)
        begin
            if (i == 0 || tab[i][25:23] != tab[i-1][25:23])
                do_reset(tab[i][25:23]);
            @(negedge clk);
            acc_page = tab[i][22:19];
            acc_addr = tab[i][18:3];
            #1;
            chk(acc_target, tab[i][2:0]);
            chk(mode_latch_bits, tab[i][25:23]);
            chk(cpu_max_mode, tab[i][25:23] inside {3'h3, 3'h4});
        end
        // single-chip mode from here on
        acc_page = 4'h0;
        chk(cpu_status_word, 16'h0700);
        chk(onchip_ram_enable, 1'b1);
        reg_acc(16'hfffa, 1'b0, 8'h00, 8'hc7);
        reg_acc(16'hfffa, 1'b1, 8'h00, 8'h00);
        reg_acc(16'hfffa, 1'b0, 8'h00, 8'hc7);
        reg_acc(16'hfff9, 1'b1, 8'h00, 8'h00);
        reg_acc(16'hfff9, 1'b0, 8'h00, 8'h00);
        chk(onchip_ram_enable, 1'b0);
        @(negedge clk);
        acc_addr = 16'hfb80;
        acc_rd = 1'b1;
        #1;
        chk(acc_target, P0M_TGT_ERR);
        chk(acc_addr_error, 1'b1);
        @(negedge clk) acc_rd = 1'b0;
        reg_acc(16'hfff9, 1'b1, 8'hff, 8'h00);
        reg_acc(16'hfff9, 1'b0, 8'h00, 8'h80);
        // status word: full write, trace, then condition byte alone
        sr_wr = 1'b1;
        sr_wdata = 16'hffff;
        @(negedge clk) sr_wr = 1'b0;
        instr_done = 1'b1;
        #1;
        chk(cpu_status_word, 16'h870f);
        chk(trace_req, 1'b1);
        @(negedge clk) instr_done = 1'b0;
        {sr_wr, sr_ccr_only, sr_wdata} = {2'h3, 16'h0300};
        @(negedge clk) {sr_wr, sr_ccr_only} = 2'h0;
        chk(cpu_status_word, 16'h8700);
        // interrupts: level equal to mask refused, nmi taken at mask 7
        irq_level = 3'h7;
        #1;
        chk(irq_accept, 1'b0);
        @(negedge clk) nmi_req = 1'b1;
        #1;
        chk(irq_accept, 1'b1);
        @(negedge clk) {nmi_req, irq_level} = 4'h0;
        chk(cpu_status_word[10:8], 3'h7);
        {sr_wr, sr_wdata} = {1'b1, 16'h0300};
        @(negedge clk) sr_wr = 1'b0;
        irq_level = 3'h5;
        #1;
        chk(irq_accept, 1'b1);
        @(negedge clk) chk(cpu_status_word, 16'h0500);
        chk(irq_accept, 1'b0);
        {nmi_req, irq_level} = 4'hb;
        #1;
        chk(irq_accept, 1'b1);
        @(negedge clk) {nmi_req, irq_level} = 4'h0;
        chk(cpu_status_word[10:8], 3'h7);
        // general registers: back-to-back writes, stack steps
        {gr_wr, gr_widx, gr_wdata} = {1'b1, 3'h7, 16'h0100};
        @(negedge clk) {gr_widx, gr_wdata, sp_predec} = {3'h6, 16'h2468, 1'b1};
        @(negedge clk) {gr_wr, sp_predec, sp_postinc, sp_byte} = 4'h3;
        chk(stack_ptr, 16'h00fe);
        chk(frame_ptr, 16'h2468);
        {gr_ridx_a, gr_ridx_b} = {3'h6, 3'h7};
        @(negedge clk) {sp_postinc, sp_byte} = 2'h0;
        chk(stack_ptr, 16'h00ff);
        chk(gr_rdata_a, 16'h2468);
        chk(gr_rdata_b, 16'h00ff);
        {gr_wr, gr_byte, gr_widx, gr_wdata} = {2'h3, 3'h6, 16'hff99};
        @(negedge clk) {gr_wr, gr_byte} = 2'h0;
        chk(frame_ptr, 16'h2499);
        // program counter: load beats advance
        {pc_load, pc_ldata, pc_adv, pc_adv_len} = {1'b1, 16'h1234, 1'b1, 3'h2};
        @(negedge clk) pc_load = 1'b0;
        chk(prog_counter, 16'h1234);
        @(negedge clk) pc_adv = 1'b0;
        chk(prog_counter, 16'h1236);
        {sr_wr, sr_wdata} = {1'b1, 16'h8000};
        @(negedge clk) sr_wr = 1'b0;
        do_reset(3'h7);
        chk(cpu_status_word, 16'h0700);
        chk(prog_counter, 16'h0000);
        final_report();
    end
endmodule
`default_nettype wire
